// ---- rtl/mpm_monitor.sv ----
// modulo folding of drive positions with limit, window and compare logic
`timescale 1ns/10ps
module mpm_monitor
  import mpm_pkg::*;
#(
  parameter int W = 32,
  parameter int NWIN = 2
)(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [6:0] regAddr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  // positions from feedback and command source
  input wire logic fbReady,
  input wire logic [W-1:0] actualPosition,
  input wire logic [W-1:0] commandPosition,
  input wire logic [W-1:0] capturedPosition0,
  input wire logic [W-1:0] capturedPosition1,
  // drive functions
  output logic haltMotion,
  output logic [NWIN-1:0] windowFlag,
  output logic doutAbove,
  output logic doutBelow,
  output logic taskStart,
  output logic [W-1:0] taskTarget,
  output logic targetWarn
);

  // refuse sizes that the folding and the register map cannot serve
  if (W < 8 || W > 32)
    $error("W must lie in 8..32");
  if (NWIN < 1 || NWIN > 5)
    $error("NWIN must lie in 1..5");

  typedef logic signed [W-1:0] pos_t;

  // ******************************************************************
  // folding arithmetic
  // ******************************************************************
  function automatic logic [W-1:0] modRem(input logic [W-1:0] u,
                                          input logic [W-1:0] r);
    logic [W:0] rem;
    rem = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      rem = {rem[W-1:0], u[i]};
      if (rem >= {1'b0, r})
        rem = rem - {1'b0, r};
    end
    return rem[W-1:0];
  endfunction

  // folds into [lo, hi); below lo folds downward so no 2^W wrap enters
  function automatic pos_t foldPos(input pos_t x, input pos_t lo,
                                   input pos_t hi);
    logic [W-1:0] r;
    logic [W-1:0] m;
    r = hi - lo;
    if (x >= lo)
    begin
      m = modRem(x - lo, r);
      return lo + pos_t'(m);
    end
    m = modRem(lo - x, r);
    return (m == '0) ? lo : hi - pos_t'(m);
  endfunction

  function automatic logic inRange(input pos_t x, input pos_t lo,
                                   input pos_t hi);
    return x >= lo && x < hi;
  endfunction

  // ******************************************************************
  // input synchronisers
  // ******************************************************************
  logic [1:0] readySync_reg;
  pos_t actS1_reg, actS2_reg, cmdS1_reg, cmdS2_reg;
  pos_t cap0S1_reg, cap0S2_reg, cap1S1_reg, cap1S2_reg;

  // multi-bit positions are assumed held steady by the source while read
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      readySync_reg <= '0;
      actS1_reg <= '0;
      actS2_reg <= '0;
      cmdS1_reg <= '0;
      cmdS2_reg <= '0;
      cap0S1_reg <= '0;
      cap0S2_reg <= '0;
      cap1S1_reg <= '0;
      cap1S2_reg <= '0;
    end
    else
    begin
      readySync_reg <= {readySync_reg[0], fbReady};
      actS1_reg <= actualPosition;
      actS2_reg <= actS1_reg;
      cmdS1_reg <= commandPosition;
      cmdS2_reg <= cmdS1_reg;
      cap0S1_reg <= capturedPosition0;
      cap0S2_reg <= cap0S1_reg;
      cap1S1_reg <= capturedPosition1;
      cap1S2_reg <= cap1S1_reg;
    end
  end

  // ******************************************************************
  // registers and decode
  // ******************************************************************
  logic modEn_reg;
  pos_t boundA_reg, boundB_reg, swLo_reg, swHi_reg, doutThr_reg;
  pos_t target_reg;
  pos_t winLo_reg [NWIN];
  pos_t winHi_reg [NWIN];

  wire wrCtrl = wrStrobe && regAddr == MPM_CTRL_OFS;
  wire wrBoundA = wrStrobe && regAddr == MPM_BOUND_A_OFS;
  wire wrBoundB = wrStrobe && regAddr == MPM_BOUND_B_OFS;
  wire wrTask = wrStrobe && regAddr == MPM_TASK_OFS;
  wire wrStatus = wrStrobe && regAddr == MPM_STATUS_OFS;
  wire taskGo = wrTask && wrData[MPM_TASK_GO_BIT];
  wire taskAbs = wrData[MPM_TASK_ABS_BIT];
  wire reconfig = wrCtrl || wrBoundA || wrBoundB;
  wire pos_t wrPos = pos_t'(wrData[W-1:0]);

  // smaller bound begins the range whichever register holds it
  wire pos_t rangeLo = (boundA_reg < boundB_reg) ? boundA_reg : boundB_reg;
  wire pos_t rangeHi = (boundA_reg < boundB_reg) ? boundB_reg : boundA_reg;
  // an empty range cannot fold, so it leaves the axis linear
  wire modActive = modEn_reg && rangeLo != rangeHi;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      modEn_reg <= MPM_EN_RST;
      boundA_reg <= pos_t'(MPM_BOUND_A_RST[W-1:0]);
      boundB_reg <= pos_t'(MPM_BOUND_B_RST[W-1:0]);
      swLo_reg <= '0;
      swHi_reg <= '0;
      doutThr_reg <= '0;
      target_reg <= '0;
      for (int i = 0; i < NWIN; i++)
      begin
        winLo_reg[i] <= '0;
        winHi_reg[i] <= '0;
      end
    end
    else if (wrStrobe)
    begin
      unique case (regAddr)
        MPM_CTRL_OFS: modEn_reg <= wrData[MPM_CTRL_EN_BIT];
        MPM_BOUND_A_OFS: boundA_reg <= wrPos;
        MPM_BOUND_B_OFS: boundB_reg <= wrPos;
        MPM_SWLIM_LO_OFS: swLo_reg <= wrPos;
        MPM_SWLIM_HI_OFS: swHi_reg <= wrPos;
        MPM_DOUT_THR_OFS: doutThr_reg <= wrPos;
        MPM_TARGET_OFS: target_reg <= wrPos;
        default:
        begin
          for (int i = 0; i < NWIN; i++)
          begin
            if (regAddr == MPM_WIN_BASE_OFS + 7'(8 * i))
              winLo_reg[i] <= wrPos;
            if (regAddr == MPM_WIN_BASE_OFS + 7'(8 * i + 4))
              winHi_reg[i] <= wrPos;
          end
        end
      endcase
    end
  end

  // ******************************************************************
  // actual position tracking
  // ******************************************************************
  mpm_state_e state_reg;
  pos_t actFold_reg, actPrev_reg;

  // tracking by deltas stays right across feedback wraps while running;
  // only a rebuild from feedback, at power-up or after a new range or enable, depends on the range dividing 2^W
  wire pos_t delta = actS2_reg - actPrev_reg;
  wire logic signed [W:0] stepSum = actFold_reg + delta;
  wire logic signed [W:0] loWide = rangeLo;
  wire logic signed [W:0] hiWide = rangeHi;
  wire pos_t stepWrap =
    (stepSum >= hiWide) ? pos_t'(stepSum - (hiWide - loWide)) :
    (stepSum < loWide) ? pos_t'(stepSum + (hiWide - loWide)) :
    pos_t'(stepSum);
  wire pos_t loadFold =
    modActive ? foldPos(actS2_reg, rangeLo, rangeHi) : actS2_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= MPM_LOAD;
      actFold_reg <= '0;
      actPrev_reg <= '0;
    end
    else
    begin
      actPrev_reg <= actS2_reg;
      unique case (state_reg)
        MPM_LOAD:
        begin
          if (readySync_reg[1] && !reconfig)
          begin
            actFold_reg <= loadFold;
            state_reg <= MPM_RUN;
          end
        end
        MPM_RUN:
        begin
          // a new range or enable rebuilds the fold from feedback
          if (reconfig)
            state_reg <= MPM_LOAD;
          else
            actFold_reg <= modActive ? stepWrap : actS2_reg;
        end
      endcase
    end
  end

  wire running = state_reg == MPM_RUN;

  // ******************************************************************
  // limit, window and compare functions
  // ******************************************************************
  wire swLoUse = !modActive || inRange(swLo_reg, rangeLo, rangeHi);
  wire swHiUse = !modActive || inRange(swHi_reg, rangeLo, rangeHi);
  wire haltNext = running &&
    ((swHiUse && actFold_reg > swHi_reg) ||
     (swLoUse && actFold_reg < swLo_reg));
  logic [NWIN-1:0] winNext;

  always_comb
  begin
    for (int i = 0; i < NWIN; i++)
      winNext[i] = running &&
        actFold_reg >= winLo_reg[i] && actFold_reg <= winHi_reg[i] &&
        (!modActive || (inRange(winLo_reg[i], rangeLo, rangeHi) &&
                        inRange(winHi_reg[i], rangeLo, rangeHi)));
  end

  // folded position never leaves the range, so an outside threshold
  // leaves both compare outputs constant
  wire aboveNext = running && actFold_reg > doutThr_reg;
  wire belowNext = running && actFold_reg < doutThr_reg;
  wire targetOut = modActive && !inRange(target_reg, rangeLo, rangeHi);
  wire warnSet = taskGo && taskAbs && targetOut;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      haltMotion <= 1'b0;
      windowFlag <= '0;
      doutAbove <= 1'b0;
      doutBelow <= 1'b0;
      taskStart <= 1'b0;
      taskTarget <= '0;
      targetWarn <= 1'b0;
    end
    else
    begin
      haltMotion <= haltNext;
      windowFlag <= winNext;
      doutAbove <= aboveNext;
      doutBelow <= belowNext;
      // an out-of-range absolute target is refused, not clipped
      taskStart <= taskGo && !warnSet;
      if (taskGo && !warnSet)
        taskTarget <= target_reg;
      // set wins over a write-one clear in the same cycle
      if (warnSet)
        targetWarn <= 1'b1;
      else if (wrStatus && wrData[MPM_STAT_WARN_BIT])
        targetWarn <= 1'b0;
    end
  end

  // ******************************************************************
  // read-back
  // ******************************************************************
  mpm_flags_s flags;
  assign flags = '{warn: targetWarn, ready: running, below: doutBelow,
                   above: doutAbove, halt: haltMotion};

  wire pos_t cmdShow =
    modActive ? foldPos(cmdS2_reg, rangeLo, rangeHi) : cmdS2_reg;
  wire pos_t cap0Show =
    modActive ? foldPos(cap0S2_reg, rangeLo, rangeHi) : cap0S2_reg;
  wire pos_t cap1Show =
    modActive ? foldPos(cap1S2_reg, rangeLo, rangeHi) : cap1S2_reg;
  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = '0;
    unique case (regAddr)
      MPM_CTRL_OFS: rdMux = 32'(modEn_reg);
      MPM_BOUND_A_OFS: rdMux = 32'(boundA_reg);
      MPM_BOUND_B_OFS: rdMux = 32'(boundB_reg);
      MPM_SWLIM_LO_OFS: rdMux = 32'(swLo_reg);
      MPM_SWLIM_HI_OFS: rdMux = 32'(swHi_reg);
      MPM_DOUT_THR_OFS: rdMux = 32'(doutThr_reg);
      MPM_TARGET_OFS: rdMux = 32'(target_reg);
      MPM_STATUS_OFS: rdMux = 32'({windowFlag, 3'h0, flags});
      MPM_ACT_POS_OFS: rdMux = 32'(actFold_reg);
      MPM_CMD_POS_OFS: rdMux = 32'(cmdShow);
      MPM_CAP0_OFS: rdMux = 32'(cap0Show);
      MPM_CAP1_OFS: rdMux = 32'(cap1Show);
      MPM_RANGE_LO_OFS: rdMux = 32'(rangeLo);
      MPM_RANGE_HI_OFS: rdMux = 32'(rangeHi);
      default:
      begin
        for (int i = 0; i < NWIN; i++)
        begin
          if (regAddr == MPM_WIN_BASE_OFS + 7'(8 * i))
            rdMux = 32'(winLo_reg[i]);
          if (regAddr == MPM_WIN_BASE_OFS + 7'(8 * i + 4))
            rdMux = 32'(winHi_reg[i]);
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdData <= '0;
    else
      rdData <= rdStrobe ? rdMux : '0;
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_halt_over_limit: assert property (
    running && swHiUse && actFold_reg > swHi_reg |=> haltMotion)
    else $error("halt missing above upper limit");
  a_limit_outside_ignored: assert property (
    running && modActive && !inRange(swHi_reg, rangeLo, rangeHi) &&
    !inRange(swLo_reg, rangeLo, rangeHi) |=> !haltMotion)
    else $error("limit outside range halted motion");
  a_window_flag_between: assert property (
    windowFlag[0] |-> $past(actFold_reg) >= $past(winLo_reg[0]) &&
                      $past(actFold_reg) <= $past(winHi_reg[0]))
    else $error("window flag outside its bounds");
  a_window_outside_quiet: assert property (
    modActive && winHi_reg[NWIN-1] >= rangeHi |=> !windowFlag[NWIN-1])
    else $error("window with outside bound asserted");
  a_dout_above_cause: assert property (
    $rose(doutAbove) |-> $past(actFold_reg) > $past(doutThr_reg))
    else $error("above output without position over threshold");
  a_dout_fixed_out: assert property (
    (running && modActive && doutThr_reg >= rangeHi)[*2] |->
    !doutAbove && doutBelow)
    else $error("compare outputs not fixed for outside threshold");
  a_task_abs_start: assert property (
    taskGo && taskAbs && !targetOut |=>
    taskStart && taskTarget == $past(target_reg))
    else $error("absolute task not started with its target");
  a_target_warn_set: assert property (
    warnSet |=> targetWarn && !taskStart)
    else $error("out-of-range target gave no warning");
  a_load_to_run: assert property (
    state_reg == MPM_LOAD && readySync_reg[1] && !reconfig |=>
    running && actFold_reg == $past(loadFold))
    else $error("power-up fold not loaded");
  a_fold_in_range: assert property (
    running && modActive |-> inRange(actFold_reg, rangeLo, rangeHi))
    else $error("folded position left the range");
  a_read_one_cycle: assert property (
    rdStrobe && regAddr == MPM_ACT_POS_OFS |=>
    rdData == 32'($past(actFold_reg)) ##1 ($past(rdStrobe) || rdData == '0))
    else $error("read data not one cycle wide");

  c_halt_seen: cover property (running ##1 $rose(haltMotion));
  c_window_seen: cover property ($rose(windowFlag[0]));
  c_warn_seen: cover property ($rose(targetWarn));
  c_wrap_seen: cover property (
    running && modActive && delta > 0 && stepSum >= hiWide);

endmodule

// ---- rtl/mpm_pkg.sv ----
// constants and types for the modulo position monitor
// ********************************************************************
// Functional notes
// - halt motion when folded actual position passes a software limit
// - a software limit outside the modulo range never halts motion
// - window flag true only while folded position lies between bounds
// - window with a bound outside the modulo range never asserts
// - output above asserts when position over threshold, below when under
// - threshold outside modulo range leaves the outputs fixed on or off
// - absolute task target is taken as a modulo-folded position
// - absolute target outside the modulo range raises the target warning
// - at power-up load feedback position and fold it
// - folding repeats exactly when range divides the feedback span
// - uneven range over many feedback wraps may rebuild a wrong fold
// - reported position wraps from range end back to range start
// - actual, command and captured positions are read back folded
// - smaller bound starts the range, larger ends it; separate enable
// ********************************************************************
package mpm_pkg;

  // register byte offsets
  localparam logic [6:0] MPM_CTRL_OFS = 7'h00;
  localparam logic [6:0] MPM_BOUND_A_OFS = 7'h04;
  localparam logic [6:0] MPM_BOUND_B_OFS = 7'h08;
  localparam logic [6:0] MPM_SWLIM_LO_OFS = 7'h0c;
  localparam logic [6:0] MPM_SWLIM_HI_OFS = 7'h10;
  localparam logic [6:0] MPM_WIN_BASE_OFS = 7'h14;
  localparam logic [6:0] MPM_DOUT_THR_OFS = 7'h40;
  localparam logic [6:0] MPM_TARGET_OFS = 7'h44;
  localparam logic [6:0] MPM_TASK_OFS = 7'h48;
  localparam logic [6:0] MPM_STATUS_OFS = 7'h4c;
  localparam logic [6:0] MPM_ACT_POS_OFS = 7'h50;
  localparam logic [6:0] MPM_CMD_POS_OFS = 7'h54;
  localparam logic [6:0] MPM_CAP0_OFS = 7'h58;
  localparam logic [6:0] MPM_CAP1_OFS = 7'h5c;
  localparam logic [6:0] MPM_RANGE_LO_OFS = 7'h60;
  localparam logic [6:0] MPM_RANGE_HI_OFS = 7'h64;

  // field positions
  localparam int MPM_CTRL_EN_BIT = 0;
  localparam int MPM_TASK_GO_BIT = 0;
  localparam int MPM_TASK_ABS_BIT = 1;
  localparam int MPM_STAT_WARN_BIT = 4;
  localparam int MPM_STAT_WIN_LSB = 8;

  // values after reset
  localparam logic MPM_EN_RST = 1'b0;
  localparam logic [31:0] MPM_BOUND_A_RST = 32'h0000_0000;
  localparam logic [31:0] MPM_BOUND_B_RST = 32'h0000_0000;

  typedef enum logic [1:0] {MPM_LOAD, MPM_RUN} mpm_state_e;

  typedef struct packed {
    logic warn;
    logic ready;
    logic below;
    logic above;
    logic halt;
  } mpm_flags_s;

endpackage

// ---- verification/mpm_feedback_model.sv ----
// behavioural multiturn feedback and command source for the monitor bench
`timescale 1ns/10ps
module mpm_feedback_model
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // position the bench wants the axis to reach
  input wire logic [31:0] goal,
  // positions and power-up valid
  output logic fbReady,
  output logic [31:0] actualPosition,
  output logic [31:0] commandPosition,
  output logic [31:0] capturedPosition0,
  output logic [31:0] capturedPosition1
);
  logic [31:0] posReg = 32'h0000_0000;
  logic [1:0] wakeReg = 2'h0;
  logic signed [31:0] gap;

  assign gap = goal - posReg;

  // small steps keep the move well inside any range the bench sets;
  // no reset here: an absolute device keeps its count over a power cycle
  always @(posedge clk)
    posReg <= (gap > 16) ? posReg + 32'h10 :
              (gap < -16) ? posReg - 32'h10 : goal;

  // position is valid only a few cycles after power returns
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      wakeReg <= 2'h0;
    else if (wakeReg != 2'h3)
      wakeReg <= wakeReg + 2'h1;

  assign fbReady = (wakeReg == 2'h3);
  assign actualPosition = posReg;
  assign commandPosition = posReg + 32'h5;
  assign capturedPosition0 = posReg - 32'h7;
  assign capturedPosition1 = posReg + 32'h64;
endmodule

// ---- verification/test_modulo_position_monitor.sv ----
// self-checking bench for the modulo position monitor
`timescale 1ns/10ps
module test_modulo_position_monitor
  import mpm_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] regAddr = 7'h00;
  logic [31:0] wrData = 32'h0, goal = 32'h0;
  logic wrStrobe = 1'b0, rdStrobe = 1'b0;
  logic [31:0] rdData, act, cmd, cap0, cap1, taskTarget, v;
  logic fbReady, haltMotion, doutAbove, doutBelow, taskStart, targetWarn;
  logic [1:0] windowFlag;
  int errors = 0, totalChecks = 0;
  longint en, bA, bB, limLo, limHi, thr;
  longint wLo[$] = '{0, 0}, wHi[$] = '{0, 0};
  bit warnExp;
  logic [31:0] thrTab[3] = '{32'h80, 32'h12c, 32'hffff_fffb};
  // last pass puts the upper limit below and the lower one above the range
  logic [31:0] hiTab[3] = '{32'hc8, 32'h190, 32'hffff_fff6};
  logic [31:0] loTab[3] = '{32'h32, 32'h32, 32'h12c};

  mpm_monitor #(.W(32), .NWIN(2)) dut (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .fbReady(fbReady),
    .actualPosition(act), .commandPosition(cmd),
    .capturedPosition0(cap0), .capturedPosition1(cap1),
    .haltMotion(haltMotion), .windowFlag(windowFlag),
    .doutAbove(doutAbove), .doutBelow(doutBelow), .taskStart(taskStart),
    .taskTarget(taskTarget), .targetWarn(targetWarn));

  mpm_feedback_model fbModel (.clk(clk), .sys_rst(sys_rst), .goal(goal),
    .fbReady(fbReady), .actualPosition(act), .commandPosition(cmd),
    .capturedPosition0(cap0), .capturedPosition1(cap1));

  initial
  begin
    forever #25 clk = ~clk;
  end

  // ****************************************
  // reference model
  // ****************************************
  function automatic longint sx(input logic [31:0] d);
    return longint'($signed(d));
  endfunction
  function automatic longint lo();
    return (bA < bB) ? bA : bB;
  endfunction
  function automatic longint hi();
    return (bA < bB) ? bB : bA;
  endfunction
  function automatic bit on();
    return en[0] && (bA != bB);
  endfunction
  function automatic bit inr(input longint t);
    return !on() || (t >= lo() && t < hi());
  endfunction
  function automatic longint fold(input longint raw);
    longint m;
    if (!on())
      return raw;
    m = (raw - lo()) % (hi() - lo());
    if (m < 0)
      m += hi() - lo();
    return lo() + m;
  endfunction

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    regAddr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    #1;
    i = (a - MPM_WIN_BASE_OFS) >> 3;
    case (a)
      MPM_CTRL_OFS: en = d[0];
      MPM_BOUND_A_OFS: bA = sx(d);
      MPM_BOUND_B_OFS: bB = sx(d);
      MPM_SWLIM_LO_OFS: limLo = sx(d);
      MPM_SWLIM_HI_OFS: limHi = sx(d);
      MPM_DOUT_THR_OFS: thr = sx(d);
      MPM_STATUS_OFS: warnExp = warnExp && !d[4];
      default:
        if (a >= MPM_WIN_BASE_OFS && i < 2)
        begin
          if (((a - MPM_WIN_BASE_OFS) & 7'h4) != 7'h0)
            wHi[i] = sx(d);
          else
            wLo[i] = sx(d);
        end
    endcase
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask

  // drive the axis to raw position p, let the pipeline settle, compare all
  task automatic visit(input longint p);
    int n;
    longint f;
    bit h, ab, be;
    bit [1:0] wf;
    n = 0;
    @(posedge clk);
    goal <= p[31:0];
    @(posedge clk);
    while (act !== p[31:0] && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    #1;
    f = fold(p);
    h = (inr(limHi) && f > limHi) || (inr(limLo) && f < limLo);
    ab = f > thr;
    be = f < thr;
    for (int i = 0; i < 2; i++)
      wf[i] = inr(wLo[i]) && inr(wHi[i]) && f >= wLo[i] && f <= wHi[i];
    check(act, p[31:0]);
    check(haltMotion, h);
    check(windowFlag, wf);
    check(doutAbove, ab);
    check(doutBelow, be);
    rd(MPM_STATUS_OFS, v);
    check(v, {22'h0, wf, 3'h0, warnExp, 1'b1, be, ab, h});
    rd(MPM_ACT_POS_OFS, v);
    check(v, f[31:0]);
    rd(MPM_CMD_POS_OFS, v);
    f = fold(p + 5);
    check(v, f[31:0]);
    rd(MPM_CAP0_OFS, v);
    f = fold(p - 7);
    check(v, f[31:0]);
    rd(MPM_CAP1_OFS, v);
    f = fold(p + 100);
    check(v, f[31:0]);
  endtask

  task automatic runTask(input longint t, input logic [31:0] c);
    bit ok;
    ok = !c[MPM_TASK_ABS_BIT] || inr(t);
    warnExp = warnExp || !ok;
    wr(MPM_TARGET_OFS, t[31:0]);
    wr(MPM_TASK_OFS, c);
    check(taskStart, ok);
    if (ok)
      check(taskTarget, t[31:0]);
    check(targetWarn, warnExp);
    @(posedge clk);
    #1;
    check(taskStart, 1'b0);
  endtask

  task automatic doReset();
    @(posedge clk);
    sys_rst <= 1'b1;
    en = 0;
    bA = 0;
    bB = 0;
    limLo = 0;
    limHi = 0;
    thr = 0;
    wLo = '{0, 0};
    wHi = '{0, 0};
    warnExp = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic setRange(input logic [31:0] a, input logic [31:0] b);
    wr(MPM_BOUND_A_OFS, a);
    wr(MPM_BOUND_B_OFS, b);
    wr(MPM_CTRL_OFS, 32'h1);
    rd(MPM_RANGE_LO_OFS, v);
    check(v, lo());
    rd(MPM_RANGE_HI_OFS, v);
    check(v, hi());
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    void'($urandom(95));
    doReset();
    rd(MPM_CTRL_OFS, v);
    check(v, {31'h0, MPM_EN_RST});
    rd(MPM_BOUND_A_OFS, v);
    check(v, MPM_BOUND_A_RST);
    rd(MPM_BOUND_B_OFS, v);
    check(v, MPM_BOUND_B_RST);
    rd(7'h7c, v);
    check(v, 32'h0);
    $display("test reset values done, errors %0d", errors);
    wr(MPM_SWLIM_HI_OFS, 32'h3e8);
    wr(MPM_DOUT_THR_OFS, 32'h64);
    visit(300);
    runTask(5000, 32'h3);
    $display("test modulo off done, errors %0d", errors);
    // bound a above bound b: the smaller one must still begin the range
    setRange(32'h100, 32'h0);
    wr(MPM_WIN_BASE_OFS, 32'h14);
    wr(MPM_WIN_BASE_OFS + 7'h4, 32'h78);
    wr(MPM_WIN_BASE_OFS + 7'h8, 32'h64);
    wr(MPM_WIN_BASE_OFS + 7'hc, 32'h12c);
    for (int k = 0; k < 3; k++)
    begin
      wr(MPM_DOUT_THR_OFS, thrTab[k]);
      wr(MPM_SWLIM_HI_OFS, hiTab[k]);
      wr(MPM_SWLIM_LO_OFS, loTab[k]);
      for (int j = 0; j < 4; j++)
        visit(longint'($urandom_range(1200)) - 300);
    end
    visit(-10);
    $display("test folded compares done, errors %0d", errors);
    runTask(100, 32'h3);
    runTask(256, 32'h3);
    runTask(256, 32'h1);
    runTask(-1, 32'h3);
    wr(MPM_STATUS_OFS, 32'h10);
    check(targetWarn, 1'b0);
    runTask(255, 32'h3);
    $display("test motion tasks done, errors %0d", errors);
    // range of 256 divides the feedback span, so the fold must survive
    visit(700);
    doReset();
    setRange(32'h100, 32'h0);
    visit(700);
    setRange(32'h400, 32'h200);
    visit(-100);
    $display("test power cycle done, errors %0d", errors);
    report_and_stop();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
